// ===== acfe_map.svh
// Constant map of the acquisition clocking front end: widths, offsets, limits, timing
`ifndef ACFE_MAP_SVH
`define ACFE_MAP_SVH

// ==========================================================
// Widths
`define ACFE_NCLK 6
`define ACFE_NQUAL 4
`define ACFE_CLK_GRP 3
`define ACFE_Q_GRP 2
`define ACFE_POD_W 17
`define ACFE_PAIR_W 34
`define ACFE_LANE_AW 13
`define ACFE_LANES 8192
`define ACFE_TAG_W 32
`define ACFE_PTR_W 14
`define ACFE_DIV_W 16

// ==========================================================
// APB register byte offsets
`define ACFE_OFF_CTRL 8'h00
`define ACFE_OFF_MARR 8'h04
`define ACFE_OFF_SARR 8'h08
`define ACFE_OFF_DIV 8'h0C
`define ACFE_OFF_STAT 8'h10
`define ACFE_OFF_RDADDR 8'h14
`define ACFE_OFF_RDDATA 8'h18
`define ACFE_OFF_RDTAG 8'h1C

// ==========================================================
// Memory limits in 17-bit lanes
`define ACFE_LIM_FULL 14'h2000
`define ACFE_LIM_TAG 14'h1000
`define ACFE_LIM_HALF 14'h2000
`define ACFE_LIM_GLITCH 14'h1000

// ==========================================================
// Timing, picoseconds, and least cycle counts at mclk
`define ACFE_MCLK_PS 5000
`define ACFE_CONV_FULL_PS 4000
`define ACFE_CONV_HALF_PS 2000
`define ACFE_TRANS_FULL_PS 8000
`define ACFE_TRANS_HALF_PS 4000
`define ACFE_GLITCH_PS 8000
`define ACFE_CYC(ps) (((ps) + `ACFE_MCLK_PS - 1) / `ACFE_MCLK_PS)

`endif

// ===== acfe_pkg.sv
// Types of the acquisition clocking front end
`include "acfe_map.svh"
package acfe_pkg;
	// ==========================================================
	// Enumerations
	typedef enum logic [2:0] {M_STATE_FULL = 3'h0, M_STATE_HALF = 3'h1, M_CONV_FULL = 3'h2,
		M_CONV_HALF = 3'h3, M_TRANS_FULL = 3'h4, M_TRANS_HALF = 3'h5,
		M_GLITCH = 3'h6} acfe_mode_t;
	typedef enum logic [1:0] {ROLE_OFF = 2'h0, ROLE_MASTER = 2'h1, ROLE_SLAVE = 2'h2,
		ROLE_DEMUX = 2'h3} acfe_role_t;
	typedef enum logic [2:0] {FS_IDLE = 3'b001, FS_RUN = 3'b010, FS_DONE = 3'b100} acfe_fsm_t;
	// ==========================================================
	// Register layouts and carriers
	typedef struct packed {acfe_role_t role_b; acfe_role_t role_a; logic tag_kind; logic tag_en;
		logic pod_sel; acfe_mode_t mode; logic stop; logic run;} acfe_ctrl_t;
	typedef struct packed {logic or_right; logic or_left; logic [`ACFE_NQUAL-1:0] q_level;
		logic [`ACFE_NQUAL-1:0] q_en; logic [`ACFE_NCLK-1:0] fall;
		logic [`ACFE_NCLK-1:0] rise;} acfe_arr_t;
	typedef struct packed {logic busy; logic done; logic [`ACFE_PTR_W-1:0] samples;
		logic [`ACFE_PTR_W-1:0] ptr;} acfe_stat_t;
	typedef struct packed {logic [`ACFE_POD_W-1:0] b; logic [`ACFE_POD_W-1:0] a;} acfe_pods_t;
	// Whole state of the front end
	typedef struct packed {acfe_fsm_t fsm; acfe_ctrl_t ctrl; acfe_arr_t marr; acfe_arr_t sarr;
		logic [`ACFE_DIV_W-1:0] div, div_cnt; logic [`ACFE_PTR_W-1:0] ptr, samp;
		logic [`ACFE_LANE_AW-1:0] rdaddr; logic [`ACFE_TAG_W-1:0] tcnt, scnt, prdata;
		logic [`ACFE_NCLK-1:0] clk_s1, clk_s2, clk_p, trig_clk, trig_valid;
		logic [`ACFE_NQUAL-1:0] q_s1, q_s2; acfe_pods_t pod_s1, pod_s2, pod_p, prev, slv;
		acfe_pods_t rise_seen, fall_seen; logic first;} acfe_st_t;
endpackage

// ===== acfe_target.sv
// Target system model driving pod data, qualifiers and clocks
`timescale 1ns/1ps
`include "acfe_map.svh"
module acfe_target (
	output logic [`ACFE_NCLK-1:0] clk_in,
	output logic [`ACFE_NQUAL-1:0] qual_in,
	output logic [`ACFE_PAIR_W-1:0] pod_in
);
	import acfe_pkg::*;
	// ==========================================================
	// Link clock, unrelated in phase to the block clock
	logic lclk = 1'b0;
	always #24 lclk = ~lclk;
	// Idle pins: clocks stand low outside frames
	initial begin
		clk_in = '0;
		qual_in = '0;
		pod_in = '0;
	end
	// ==========================================================
	// One clocked frame: data first, edge mid-frame, then release
	task automatic strobe(input logic [5:0] c, input logic [3:0] q, input logic [33:0] d);
		@(posedge lclk);
		pod_in <= d;
		qual_in <= q;
		@(posedge lclk);
		clk_in <= c;
		@(posedge lclk);
		clk_in <= '0;
		@(posedge lclk);
		// Hold time over: old value must not linger
		pod_in <= ~d;
		qual_in <= ~q;
	endtask
	// Unclocked level change for timing modes
	task automatic level(input logic [33:0] d);
		@(posedge lclk);
		pod_in <= d;
	endtask
endmodule // acfe_target

// ===== acfe_top.sv
// Acquisition clocking front end: pod sampling, clock arrangements, capture memory, APB
`timescale 1ns/1ps
`include "acfe_map.svh"
module acfe_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`ACFE_NCLK-1:0] clk_in,
	input wire logic [`ACFE_NQUAL-1:0] qual_in,
	input wire logic [`ACFE_PAIR_W-1:0] pod_in,
	output logic [`ACFE_NCLK-1:0] trig_clk_data,
	output logic [`ACFE_NCLK-1:0] trig_clk_valid,
	output acfe_pkg::acfe_pods_t range_data,
	output logic acq_busy,
	output logic acq_done
);
	import acfe_pkg::*;

	// ==========================================================
	// Functions

	// One qualifier group: all enabled terms ANDed, or any ORed; none enabled is true
	function automatic logic qual_comb(input logic [`ACFE_Q_GRP-1:0] ok,
		input logic [`ACFE_Q_GRP-1:0] en, input logic use_or);
		logic r;
		if (en == '0) begin
			r = 1'b1;
		end else if (use_or) begin
			r = |(ok & en);
		end else begin
			r = &(ok | ~en);
		end
		return r;
	endfunction

	// Clock arrangement match over six clocks and four qualifiers
	function automatic logic arr_match(input acfe_arr_t a, input logic [`ACFE_NCLK-1:0] re,
		input logic [`ACFE_NCLK-1:0] fe, input logic [`ACFE_NQUAL-1:0] ql);
		logic [`ACFE_NCLK-1:0] hit;
		logic [`ACFE_NQUAL-1:0] ok;
		logic lq;
		logic rq;
		hit = (re & a.rise) | (fe & a.fall);
		ok = ~(ql ^ a.q_level);
		lq = qual_comb(ok[`ACFE_Q_GRP-1:0], a.q_en[`ACFE_Q_GRP-1:0], a.or_left);
		rq = qual_comb(ok[`ACFE_NQUAL-1:`ACFE_Q_GRP], a.q_en[`ACFE_NQUAL-1:`ACFE_Q_GRP],
			a.or_right);
		// Left group and right group simply ORed
		return ((|hit[`ACFE_CLK_GRP-1:0]) & lq) | ((|hit[`ACFE_NCLK-1:`ACFE_CLK_GRP]) & rq);
	endfunction

	// Value stored for a pod by its clocking role
	function automatic logic [`ACFE_POD_W-1:0] lane_val(input acfe_role_t r,
		input logic [`ACFE_POD_W-1:0] live, input logic [`ACFE_POD_W-1:0] held);
		logic [`ACFE_POD_W-1:0] v;
		case (r)
			ROLE_MASTER: v = live;
			ROLE_SLAVE: v = held;
			default: v = '0;
		endcase
		return v;
	endfunction

	// Least sample interval in mclk cycles for each timing mode
	function automatic logic [`ACFE_DIV_W-1:0] min_cyc(input acfe_mode_t m);
		logic [`ACFE_DIV_W-1:0] c;
		case (m)
			M_CONV_FULL: c = `ACFE_DIV_W'(`ACFE_CYC(`ACFE_CONV_FULL_PS));
			M_CONV_HALF: c = `ACFE_DIV_W'(`ACFE_CYC(`ACFE_CONV_HALF_PS));
			M_TRANS_FULL: c = `ACFE_DIV_W'(`ACFE_CYC(`ACFE_TRANS_FULL_PS));
			M_TRANS_HALF: c = `ACFE_DIV_W'(`ACFE_CYC(`ACFE_TRANS_HALF_PS));
			M_GLITCH: c = `ACFE_DIV_W'(`ACFE_CYC(`ACFE_GLITCH_PS));
			default: c = `ACFE_DIV_W'(`ACFE_CYC(`ACFE_MCLK_PS));
		endcase
		return c;
	endfunction

	// Memory limit in lanes for a mode
	function automatic logic [`ACFE_PTR_W-1:0] lane_lim(input acfe_mode_t m, input logic tg);
		logic [`ACFE_PTR_W-1:0] l;
		case (m)
			M_STATE_FULL: l = tg ? `ACFE_LIM_TAG : `ACFE_LIM_FULL;
			M_GLITCH: l = `ACFE_LIM_GLITCH;
			M_STATE_HALF, M_CONV_HALF, M_TRANS_HALF: l = `ACFE_LIM_HALF;
			default: l = `ACFE_LIM_FULL;
		endcase
		return l;
	endfunction

	// Decoded register addresses
	function automatic logic is_mapped(input logic [7:0] a);
		return (a == `ACFE_OFF_CTRL) || (a == `ACFE_OFF_MARR) || (a == `ACFE_OFF_SARR) ||
			(a == `ACFE_OFF_DIV) || (a == `ACFE_OFF_STAT) || (a == `ACFE_OFF_RDADDR) ||
			(a == `ACFE_OFF_RDDATA) || (a == `ACFE_OFF_RDTAG);
	endfunction

	// ==========================================================
	// State and storage
	acfe_st_t q; // Registered state
	acfe_st_t d; // Next state
	logic [`ACFE_POD_W-1:0] mem [`ACFE_LANES]; // Capture lanes, no reset
	logic [`ACFE_TAG_W-1:0] tagm [`ACFE_LANES]; // Tag per stored sample
	logic w0_en; // Lane write port 0
	logic [`ACFE_LANE_AW-1:0] w0_addr;
	logic [`ACFE_POD_W-1:0] w0_data;
	logic w1_en; // Lane write port 1
	logic [`ACFE_LANE_AW-1:0] w1_addr;
	logic [`ACFE_POD_W-1:0] w1_data;
	logic t_en; // Tag write port
	logic [`ACFE_LANE_AW-1:0] t_addr;
	logic [`ACFE_TAG_W-1:0] t_data;

	// Working values of the next-state process
	logic [`ACFE_NCLK-1:0] crise; // Clock edges after synchroniser
	logic [`ACFE_NCLK-1:0] cfall;
	logic m_hit; // Master arrangement matched
	logic s_hit; // Slave arrangement matched
	logic tick; // Internal sample clock enable
	logic is_timing;
	logic [`ACFE_DIV_W-1:0] eff; // Effective sample interval
	logic [`ACFE_POD_W-1:0] sel_live; // Selected pod live data
	logic [`ACFE_POD_W-1:0] sel_held; // Selected pod slave latch
	acfe_role_t sel_role;
	acfe_pods_t prise; // Data channel edges this cycle
	acfe_pods_t pfall;
	acfe_pods_t rs; // Edges seen in the current period
	acfe_pods_t fs;
	logic [`ACFE_POD_W-1:0] gflag; // Glitch flags of selected pod
	logic do_w; // Store a sample this cycle
	logic two; // Sample takes two lanes
	logic tag; // Sample also takes a tag
	logic [`ACFE_POD_W-1:0] l0; // Lane data
	logic [`ACFE_POD_W-1:0] l1;
	logic [`ACFE_PTR_W-1:0] nptr; // Lane pointer after the write
	logic setup; // APB setup phase
	logic access; // APB access phase

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		w0_en = 1'b0;
		w0_addr = '0;
		w0_data = '0;
		w1_en = 1'b0;
		w1_addr = '0;
		w1_data = '0;
		t_en = 1'b0;
		t_addr = '0;
		t_data = '0;
		do_w = 1'b0;
		two = 1'b0;
		tag = 1'b0;
		l0 = '0;
		l1 = '0;
		nptr = '0; // Only meaningful on a write; defaulted so no latch forms
		tick = 1'b0;
		setup = psel & ~penable;
		access = psel & penable;

		// Two-flop synchronisers; the first stage feeds only the second
		d.clk_s1 = clk_in;
		d.clk_s2 = q.clk_s1;
		d.clk_p = q.clk_s2;
		d.q_s1 = qual_in;
		d.q_s2 = q.q_s1;
		d.pod_s1 = acfe_pods_t'(pod_in);
		d.pod_s2 = q.pod_s1;
		d.pod_p = q.pod_s2;

		// Edges of target clocks, seen only at mclk resolution
		crise = q.clk_s2 & ~q.clk_p;
		cfall = ~q.clk_s2 & q.clk_p;
		m_hit = arr_match(q.marr, crise, cfall, q.q_s2);
		s_hit = arr_match(q.sarr, crise, cfall, q.q_s2);

		// Clocks no arrangement uses are offered to the triggers
		d.trig_clk = q.clk_s2;
		d.trig_valid = ~(q.marr.rise | q.marr.fall | q.sarr.rise | q.sarr.fall);

		// Selected pod of the pair
		sel_live = q.ctrl.pod_sel ? q.pod_s2.b : q.pod_s2.a;
		sel_held = q.ctrl.pod_sel ? q.slv.b : q.slv.a;
		sel_role = q.ctrl.pod_sel ? q.ctrl.role_b : q.ctrl.role_a;

		// Internal sample clock; never faster than the mode allows
		is_timing = (q.ctrl.mode == M_CONV_FULL) || (q.ctrl.mode == M_CONV_HALF) ||
			(q.ctrl.mode == M_TRANS_FULL) || (q.ctrl.mode == M_TRANS_HALF) ||
			(q.ctrl.mode == M_GLITCH);
		eff = (q.div > min_cyc(q.ctrl.mode)) ? q.div : min_cyc(q.ctrl.mode);
		if ((q.fsm == FS_RUN) && is_timing) begin
			if (q.div_cnt >= eff - `ACFE_DIV_W'(1)) begin
				tick = 1'b1;
				d.div_cnt = '0;
			end else begin
				d.div_cnt = q.div_cnt + `ACFE_DIV_W'(1);
			end
		end else begin
			d.div_cnt = '0;
		end

		// Edge pairs between samples; pulses under one mclk period can be missed
		prise = q.pod_s2 & ~q.pod_p;
		pfall = ~q.pod_s2 & q.pod_p;
		rs = q.rise_seen | prise;
		fs = q.fall_seen | pfall;
		gflag = q.ctrl.pod_sel ? (rs.b & fs.b) : (rs.a & fs.a);
		if (tick) begin
			d.rise_seen = '0;
			d.fall_seen = '0;
		end else begin
			d.rise_seen = rs;
			d.fall_seen = fs;
		end

		// Acquisition while running
		if (q.fsm == FS_RUN) begin
			d.tcnt = q.tcnt + `ACFE_TAG_W'(1);
			if (m_hit && !is_timing) begin
				d.scnt = q.scnt + `ACFE_TAG_W'(1);
			end
			// Slave latch: newest event wins, else it holds
			if (s_hit && !is_timing) begin
				if ((q.ctrl.role_a == ROLE_SLAVE) ||
					((q.ctrl.role_a == ROLE_DEMUX) && !q.ctrl.pod_sel)) begin
					d.slv.a = q.pod_s2.a;
				end
				if ((q.ctrl.role_b == ROLE_SLAVE) ||
					((q.ctrl.role_b == ROLE_DEMUX) && q.ctrl.pod_sel)) begin
					d.slv.b = q.pod_s2.b;
				end
			end
			case (q.ctrl.mode)
				M_STATE_FULL: begin
					if (m_hit) begin
						do_w = 1'b1;
						two = 1'b1;
						tag = q.ctrl.tag_en;
						if (sel_role == ROLE_DEMUX) begin
							l0 = sel_live;
							l1 = sel_held;
						end else begin
							l0 = lane_val(q.ctrl.role_a, q.pod_s2.a, q.slv.a);
							l1 = lane_val(q.ctrl.role_b, q.pod_s2.b, q.slv.b);
						end
					end
				end
				M_STATE_HALF: begin
					if (m_hit) begin
						do_w = 1'b1;
						if (sel_role == ROLE_DEMUX) begin
							two = 1'b1;
							l0 = sel_live;
							l1 = sel_held;
						end else begin
							l0 = lane_val(sel_role, sel_live, sel_held);
						end
					end
				end
				M_CONV_FULL: begin
					do_w = tick;
					two = 1'b1;
					l0 = q.pod_s2.a;
					l1 = q.pod_s2.b;
				end
				M_CONV_HALF: begin
					do_w = tick;
					l0 = sel_live;
				end
				M_TRANS_FULL: begin
					if (tick) begin
						do_w = q.first || (q.pod_s2 != q.prev);
						d.prev = q.pod_s2;
						d.first = 1'b0;
					end
					two = 1'b1;
					tag = 1'b1;
					l0 = q.pod_s2.a;
					l1 = q.pod_s2.b;
				end
				M_TRANS_HALF: begin
					if (tick) begin
						do_w = q.first || (sel_live != q.prev.a);
						d.prev.a = sel_live;
						d.first = 1'b0;
					end
					tag = 1'b1;
					l0 = sel_live;
				end
				M_GLITCH: begin
					do_w = tick;
					two = 1'b1;
					l0 = sel_live;
					l1 = gflag;
				end
				default: begin
					do_w = 1'b0;
				end
			endcase
			// Lane and tag writes, then the depth check
			if (do_w) begin
				w0_en = 1'b1;
				w0_addr = q.ptr[`ACFE_LANE_AW-1:0];
				w0_data = l0;
				w1_en = two;
				w1_addr = `ACFE_LANE_AW'(q.ptr + `ACFE_PTR_W'(1));
				w1_data = l1;
				t_en = tag;
				t_addr = q.samp[`ACFE_LANE_AW-1:0];
				t_data = (is_timing || !q.ctrl.tag_kind) ? q.tcnt : q.scnt;
				nptr = q.ptr + (two ? `ACFE_PTR_W'(2) : `ACFE_PTR_W'(1));
				d.ptr = nptr;
				d.samp = q.samp + `ACFE_PTR_W'(1);
				if (nptr >= lane_lim(q.ctrl.mode, q.ctrl.tag_en)) begin
					d.fsm = FS_DONE;
				end
			end
		end

		// Read data captured in the setup phase, shown in the access phase
		if (setup) begin
			case (paddr)
				`ACFE_OFF_CTRL: d.prdata = 32'(q.ctrl);
				`ACFE_OFF_MARR: d.prdata = 32'(q.marr);
				`ACFE_OFF_SARR: d.prdata = 32'(q.sarr);
				`ACFE_OFF_DIV: d.prdata = 32'(q.div);
				`ACFE_OFF_STAT: d.prdata = 32'(acfe_stat_t'({q.fsm == FS_RUN,
					q.fsm == FS_DONE, q.samp, q.ptr}));
				`ACFE_OFF_RDADDR: d.prdata = 32'(q.rdaddr);
				`ACFE_OFF_RDDATA: d.prdata = 32'(mem[q.rdaddr]);
				`ACFE_OFF_RDTAG: d.prdata = tagm[q.rdaddr];
				default: d.prdata = '0;
			endcase
		end

		// Register writes and read side effects; software start wins over capture
		if (access && pwrite) begin
			case (paddr)
				`ACFE_OFF_CTRL: begin
					d.ctrl = acfe_ctrl_t'(pwdata[$bits(acfe_ctrl_t)-1:0]);
					d.ctrl.run = 1'b0;
					d.ctrl.stop = 1'b0;
					if (pwdata[0]) begin
						d.fsm = FS_RUN;
						d.ptr = '0;
						d.samp = '0;
						d.tcnt = '0;
						d.scnt = '0;
						d.div_cnt = '0;
						d.slv = '0;
						d.prev = '0;
						d.rise_seen = '0;
						d.fall_seen = '0;
						d.first = 1'b1;
					end else if (pwdata[1] && (q.fsm == FS_RUN)) begin
						d.fsm = FS_DONE;
					end
				end
				`ACFE_OFF_MARR: d.marr = acfe_arr_t'(pwdata[$bits(acfe_arr_t)-1:0]);
				`ACFE_OFF_SARR: d.sarr = acfe_arr_t'(pwdata[$bits(acfe_arr_t)-1:0]);
				`ACFE_OFF_DIV: d.div = pwdata[`ACFE_DIV_W-1:0];
				`ACFE_OFF_RDADDR: d.rdaddr = pwdata[`ACFE_LANE_AW-1:0];
				default: d.div = q.div;
			endcase
		end else if (access && (paddr == `ACFE_OFF_RDDATA)) begin
			// Reading a lane steps to the next one
			d.rdaddr = q.rdaddr + `ACFE_LANE_AW'(1);
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			q <= '0;
			q.fsm <= FS_IDLE;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Capture memory; flops only, so no reset is needed
	always_ff @(posedge mclk) begin
		if (w0_en) begin
			mem[w0_addr] <= w0_data;
		end
		if (w1_en) begin
			mem[w1_addr] <= w1_data;
		end
		if (t_en) begin
			tagm[t_addr] <= t_data;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = q.prdata;
	assign pready = 1'b1; // Zero wait states
	assign pslverr = access & ~is_mapped(paddr);
	assign trig_clk_data = q.trig_clk;
	assign trig_clk_valid = q.trig_valid;
	assign range_data = q.pod_s2; // Range compare sees pod data only
	assign acq_busy = (q.fsm == FS_RUN);
	assign acq_done = (q.fsm == FS_DONE);

endmodule // acfe_top

// ===== acfe_top_assertions.sv
// Checker of the front end port relations, bound onto the top module
`timescale 1ns/1ps
`include "acfe_map.svh"
module acfe_chk (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [`ACFE_NCLK-1:0] clk_in,
	input wire logic [`ACFE_PAIR_W-1:0] pod_in,
	input wire logic [`ACFE_NCLK-1:0] trig_clk_data,
	input wire acfe_pkg::acfe_pods_t range_data,
	input wire logic acq_busy,
	input wire logic acq_done
);
	import acfe_pkg::*;
	// ==========================================================
	// Common clock, reset and decode
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire acc = psel && penable; // Access phase
	wire ctl_wr = acc && pwrite && paddr == `ACFE_OFF_CTRL; // Control write
	// ==========================================================
	// Bus
	AST_READY: assert property (pready) else $error("pready low");
	AST_UNMAPPED: assert property (acc && !pwrite && paddr == 8'h20 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	AST_MAPPED: assert property (acc && paddr == `ACFE_OFF_STAT |-> !pslverr)
		else $error("mapped access refused");
	// Status read agrees with the run flags once they have settled
	AST_STAT: assert property ($stable({acq_busy, acq_done}) [*3] ##0 (acc && !pwrite &&
		paddr == `ACFE_OFF_STAT) |-> prdata[29:28] == {acq_busy, acq_done})
		else $error("status bits disagree with flags");
	// ==========================================================
	// Run control
	AST_EXCL: assert property (!(acq_busy && acq_done)) else $error("busy and done together");
	AST_START: assert property (ctl_wr && pwdata[0] && pwdata[4:2] != 3'h7 |=> acq_busy)
		else $error("run write did not start");
	AST_STOP: assert property (ctl_wr && pwdata[1:0] == 2'b10 && acq_busy |=> acq_done && !acq_busy)
		else $error("stop write did not end run");
	AST_DONE_HOLD: assert property (acq_done && !ctl_wr |=> acq_done) else $error("done dropped");
	// ==========================================================
	// Synchronised pins: slack of five cycles covers both sync depths
	AST_CLK_SYNC: assert property ($stable(clk_in) [*5] |-> trig_clk_data == clk_in)
		else $error("clock levels not passed on");
	AST_POD_SYNC: assert property ($stable(pod_in) [*5] |-> range_data == pod_in)
		else $error("pod data not passed on");
	// ==========================================================
	// Main scenarios seen
	COV_DONE: cover property ($rose(acq_done));
	COV_ERR: cover property (acc && pslverr);
	COV_CLK: cover property ($rose(trig_clk_data[0]));
endmodule // acfe_chk

bind acfe_top acfe_chk u_acfe_chk (.*);

// ===== acfe_top_tb.sv
// Self-checking bench of the acquisition clocking front end
`timescale 1ns/1ps
`include "acfe_map.svh"
module acfe_top_tb;
	import acfe_pkg::*;
	// ==========================================================
	// Signals
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] paddr; // Bus driven from the first clock edge on
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [`ACFE_NCLK-1:0] clk_in;
	logic [`ACFE_NQUAL-1:0] qual_in;
	logic [`ACFE_PAIR_W-1:0] pod_in;
	logic [`ACFE_NCLK-1:0] trig_clk_data;
	logic [`ACFE_NCLK-1:0] trig_clk_valid;
	acfe_pods_t range_data;
	logic acq_busy;
	logic acq_done;
	int miscompares = 0;
	int n_checks = 0;
	logic [31:0] rd; // Last read data
	logic err; // Last error response
	always #2.5 mclk = ~mclk;
	acfe_top u_acfe_top (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clk_in(clk_in), .qual_in(qual_in),
		.pod_in(pod_in), .trig_clk_data(trig_clk_data), .trig_clk_valid(trig_clk_valid),
		.range_data(range_data), .acq_busy(acq_busy), .acq_done(acq_done));
	acfe_target u_acfe_target (.clk_in(clk_in), .qual_in(qual_in), .pod_in(pod_in));
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++;
			conclude();
		end
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] m, input logic ps,
		input logic [1:0] ra, input logic [1:0] rb, input logic [1:0] op);
		return {20'h0, rb, ra, 2'b00, ps, m, op};
	endfunction
	task automatic fetch(input logic [31:0] a);
		xfer(1'b1, `ACFE_OFF_RDADDR, a);
		xfer(1'b0, `ACFE_OFF_RDDATA, 32'h0);
	endtask
	task automatic stat();
		cyc(12);
		xfer(1'b0, `ACFE_OFF_STAT, 32'h0);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		xfer(1'b0, `ACFE_OFF_CTRL, 32'h0);
		check(rd, 34'h0, "ctrl reset");
		xfer(1'b0, `ACFE_OFF_STAT, 32'h0);
		check(rd, 34'h0, "stat reset");
		xfer(1'b0, 8'h20, 32'h0);
		check({err, rd}, {1'b1, 32'h0}, "unmapped");
	endtask
	// Master on clock 0 rise, slave on clock 1 rise, pod B slave
	task automatic t_master_slave();
		xfer(1'b1, `ACFE_OFF_MARR, 32'h1);
		xfer(1'b1, `ACFE_OFF_SARR, 32'h2);
		xfer(1'b1, `ACFE_OFF_CTRL, ctl(3'h0, 1'b0, 2'h1, 2'h2, 2'b01));
		cyc(3);
		check(trig_clk_valid, 6'h3C, "free clocks");
		u_acfe_target.strobe(6'h02, 4'h0, {17'h01111, 17'h00000});
		u_acfe_target.strobe(6'h02, 4'h0, {17'h12222, 17'h00000});
		u_acfe_target.strobe(6'h01, 4'h0, {17'h1FFFF, 17'h03333});
		u_acfe_target.strobe(6'h01, 4'h0, {17'h1FFFF, 17'h14444});
		stat();
		check(rd[27:0], {14'h2, 14'h4}, "state full count");
		fetch(0);
		check(rd[16:0], 17'h03333, "master 0");
		fetch(1);
		check(rd[16:0], 17'h12222, "slave 0");
		fetch(2);
		check(rd[16:0], 17'h14444, "master 1");
		fetch(3);
		check(rd[16:0], 17'h12222, "slave 1");
	endtask
	task automatic t_demux();
		// State count tags on: tag n is the master count before sample n
		xfer(1'b1, `ACFE_OFF_CTRL, ctl(3'h0, 1'b0, 2'h3, 2'h0, 2'b01) | 32'hC0);
		u_acfe_target.strobe(6'h02, 4'h0, {17'h00000, 17'h05555});
		u_acfe_target.strobe(6'h02, 4'h0, {17'h00000, 17'h16666});
		u_acfe_target.strobe(6'h01, 4'h0, {17'h00000, 17'h07777});
		u_acfe_target.strobe(6'h01, 4'h0, {17'h00000, 17'h00001});
		cyc(12);
		fetch(0);
		check(rd[16:0], 17'h07777, "demux master");
		fetch(1);
		check(rd[16:0], 17'h16666, "demux slave");
		xfer(1'b1, `ACFE_OFF_RDADDR, 32'h1);
		xfer(1'b0, `ACFE_OFF_RDTAG, 32'h0);
		check(rd, 34'h1, "state tag");
	endtask
	task automatic t_half();
		xfer(1'b1, `ACFE_OFF_CTRL, ctl(3'h1, 1'b1, 2'h0, 2'h1, 2'b01));
		u_acfe_target.strobe(6'h01, 4'h0, {17'h15A5A, 17'h0AAAA});
		stat();
		check(rd[27:0], {14'h1, 14'h1}, "half count");
		fetch(0);
		check(rd[16:0], 17'h15A5A, "half pod");
	endtask
	// Left: clock 2 with Q0; right: clock 5 with Q2
	task automatic t_combine();
		xfer(1'b1, `ACFE_OFF_MARR, {10'h0, 2'b00, 4'h5, 4'h5, 6'h00, 6'h24});
		xfer(1'b1, `ACFE_OFF_SARR, 32'h0);
		xfer(1'b1, `ACFE_OFF_CTRL, ctl(3'h0, 1'b0, 2'h1, 2'h0, 2'b01));
		u_acfe_target.strobe(6'h04, 4'h0, 34'h0);
		u_acfe_target.strobe(6'h04, 4'h1, 34'h0);
		u_acfe_target.strobe(6'h20, 4'h4, 34'h0);
		u_acfe_target.strobe(6'h20, 4'h1, 34'h0);
		u_acfe_target.strobe(6'h18, 4'hF, 34'h0);
		stat();
		check(rd[27:14], 14'h2, "qualified edges");
		check(trig_clk_valid, 6'h1B, "combine free clocks");
	endtask
	// Depth limits at the shortest interval
	task automatic t_limits();
		logic [2:0] m[3] = '{3'h2, 3'h3, 3'h6};
		int ex[3] = '{4096, 8192, 2048};
		int per[3] = '{1, 1, 2};
		int n;
		xfer(1'b1, `ACFE_OFF_DIV, 32'h0);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, `ACFE_OFF_CTRL, ctl(m[i], 1'b0, 2'h0, 2'h0, 2'b01));
			cyc(1);
			n = 0;
			while (acq_done !== 1'b1 && n < 20000) begin
				@(posedge mclk);
				n++;
			end
			if (n >= 20000) begin
				miscompares++;
				conclude();
			end
			xfer(1'b0, `ACFE_OFF_STAT, 32'h0);
			check(rd[29:14], {2'b01, ex[i][13:0]}, "depth");
			check(n >= ex[i] * per[i] - 4 && n <= ex[i] * per[i] + 8, 1'b1, "rate");
		end
	endtask
	task automatic t_trans();
		logic [31:0] t0;
		u_acfe_target.level(34'h0);
		xfer(1'b1, `ACFE_OFF_DIV, 32'h4);
		xfer(1'b1, `ACFE_OFF_CTRL, ctl(3'h4, 1'b0, 2'h0, 2'h0, 2'b01));
		cyc(60);
		xfer(1'b0, `ACFE_OFF_STAT, 32'h0);
		check(rd[27:14], 14'h1, "steady pods");
		u_acfe_target.level({17'h10000, 17'h00001});
		stat();
		check(rd[27:0], {14'h2, 14'h4}, "one change");
		xfer(1'b1, `ACFE_OFF_RDADDR, 32'h0);
		xfer(1'b0, `ACFE_OFF_RDTAG, 32'h0);
		t0 = rd;
		xfer(1'b1, `ACFE_OFF_RDADDR, 32'h1);
		xfer(1'b0, `ACFE_OFF_RDTAG, 32'h0);
		check(rd - t0 >= 32'h3C, 1'b1, "time tag");
	endtask
	task automatic t_glitch();
		logic [16:0] f;
		int n;
		u_acfe_target.level(34'h0);
		xfer(1'b1, `ACFE_OFF_DIV, 32'hC8);
		xfer(1'b1, `ACFE_OFF_CTRL, ctl(3'h6, 1'b0, 2'h0, 2'h0, 2'b01));
		// Two pulses half a period apart: one cannot straddle a tick
		u_acfe_target.level(34'h1);
		u_acfe_target.level(34'h0);
		cyc(100);
		u_acfe_target.level(34'h1);
		u_acfe_target.level(34'h0);
		cyc(400);
		xfer(1'b1, `ACFE_OFF_CTRL, ctl(3'h6, 1'b0, 2'h0, 2'h0, 2'b10));
		xfer(1'b0, `ACFE_OFF_STAT, 32'h0);
		n = rd[27:14];
		f = 17'h0;
		for (int i = 0; i < n; i++) begin
			fetch(2 * i + 1);
			f |= rd[16:0];
		end
		check(f, 17'h00001, "glitch flags");
		check(n >= 2, 1'b1, "glitch ticks");
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		// Bus idle from the first edge; reset spans eight edges in all
		@(posedge mclk);
		paddr <= 8'h00;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		pwdata <= 32'h0;
		repeat (7) @(posedge mclk);
		nrst <= 1'b1;
		t_reset();
		t_master_slave();
		t_demux();
		t_half();
		t_combine();
		t_limits();
		t_trans();
		t_glitch();
		conclude();
	end
endmodule // acfe_top_tb
